// >>> lvx_low_vector.sv
`timescale 1ns/10ps
// Notes on behaviour
// - debug exception from breakpoints, steps, data, io, task, general detect, and opcode f1
// - each debug cause except opcode f1 gated by debug control enables, the general-detect bit or the single-step flag
// - debug exception has no error code; cause reported in debug status
// - instruction and general-detect debug are faults; others are traps
// - resume flag cleared after each instruction; delayed after return, jump, call, task int
// - non-debug exception or interrupted string pushes resume flag as one
// - resume flag set suppresses instruction breakpoint once, then is cleared
// - debug exception pushes resume flag as zero
// - handler-set resume flag suppresses breakpoint for one instruction only
// - nmi on vector 2, taken at instruction boundary, points to next
// - nmi unmaskable but blocked after recognition until interrupt return
// - breakpoint instruction traps on vector 3, no error code, points after
// - overflow check with overflow flag one traps on vector 4
// - index outside bounds faults on vector 5 pointing at the instruction
// - invalid opcode on reserved, undefined, bad lock, bad operand
// - legacy instructions invalid in 64-bit mode incl. far call and far jump
// - fast syscalls invalid in long mode; sysmgmt return invalid outside sysmgmt mode
// - descriptor instructions invalid outside protected mode or in v86
// - vector instr invalid without save support, or any media with emulation
// - unmasked vector fp invalid without support; debug reg 4/5 invalid with extensions
// - invalid opcode is a fault with no error code, pointing at instruction
module lvx_low_vector
    import lvx_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  srst,
    // retire / boundary from the pipeline
    input  wire logic                  insn_valid,
    input  wire logic                  insn_done,
    input  wire lvx_pkg::lvx_iclass_t  insn_class,
    input  wire logic [7:0]            insn_opcode,
    input  wire logic                  insn_reserved,
    input  wire logic                  insn_lock,
    input  wire logic                  insn_lockable,
    input  wire logic                  insn_mem_target,
    input  wire logic                  insn_bad_operand,
    input  wire logic                  insn_legacy64,
    input  wire logic                  insn_string_intr,
    input  wire logic                  insn_legacy_vec,
    input  wire logic                  insn_media,
    input  wire logic                  insn_vec_fp_numexc,
    input  wire logic [2:0]            insn_dreg_num,
    input  wire logic                  bound_index_gt,
    input  wire logic [63:0]           bound_index,
    input  wire logic [63:0]           bound_lower,
    input  wire logic [63:0]           bound_upper,
    // debug condition matches (raw, before enables)
    input  wire logic [LVX_DC_W-1:0]   dbg_match,
    // enables from debug control register (step and general-detect bits unused)
    input  wire logic [LVX_DC_W-1:0]   debug_control_register,
    input  wire logic                  general_detect_bit,
    input  wire logic                  single_step_flag,
    input  wire logic                  overflow_flag,
    // resume flag load from interrupt return
    input  wire logic                  resume_flag_load,
    input  wire logic                  resume_flag_value,
    // mode and control bits
    input  wire logic                  mode_64bit,
    input  wire logic                  mode_long,
    input  wire logic                  mode_protected,
    input  wire logic                  mode_v86,
    input  wire logic                  system_management_mode,
    input  wire logic                  os_vector_save_support_bit,
    input  wire logic                  os_vector_exception_support_bit,
    input  wire logic                  emulation_bit,
    input  wire logic                  debug_extensions_bit,
    // external non-maskable request
    input  wire logic                  nmi_req,
    // to dispatch
    output logic                       exc_valid_q,
    output logic [7:0]                 exc_vector_q,
    output logic                       exc_fault_q,
    output logic                       exc_pushed_rf_q,
    output logic                       resume_flag_q,
    output logic [LVX_DC_W-1:0]        debug_status_register_q,
    output logic                       nmi_blocked_q
);
    // ------------------------------------------------------------
    // bounds check
    // ------------------------------------------------------------
    logic bound_out_q;
    logic bound_pend_q;

    lvx_bound_cmp u_bound
    (
        .clk       (clk),
        .srst      (srst),
        .index     (bound_index),
        .lower     (bound_lower),
        .upper     (bound_upper),
        .outside_q (bound_out_q)
    );

    // bound result arrives one cycle after the instruction, so it holds retire
    wire bound_fault  = bound_pend_q && bound_out_q;

    // ------------------------------------------------------------
    // invalid opcode decode
    // ------------------------------------------------------------
    wire is_cls_dreg  = insn_class == LVX_IC_DREG;
    wire ud_basic     = insn_reserved || (insn_class == LVX_IC_UNDEF)
                        || (insn_lock && !insn_lockable)
                        || (insn_lock && !insn_mem_target)
                        || insn_bad_operand;
    wire ud_64        = mode_64bit && (insn_legacy64
                        || insn_opcode == LVX_OP_FAR_CALL
                        || insn_opcode == LVX_OP_FAR_JMP);
    wire ud_sys       = (insn_class == LVX_IC_SYSFAST && mode_long)
                        || (insn_class == LVX_IC_SMX && !system_management_mode);
    wire ud_desc      = insn_class == LVX_IC_DESC && (!mode_protected || mode_v86);
    wire ud_vec       = (insn_legacy_vec && !os_vector_save_support_bit)
                        || ((insn_legacy_vec || insn_media) && emulation_bit);
    wire ud_fp_dreg   = (insn_vec_fp_numexc && !os_vector_exception_support_bit)
                        || (is_cls_dreg && debug_extensions_bit
                            && (insn_dreg_num == 3'h4 || insn_dreg_num == 3'h5));
    wire invop        = insn_valid && !bound_pend_q
                        && (ud_basic || ud_64 || ud_sys || ud_desc || ud_vec || ud_fp_dreg);
    // an invalid bound faults at once and never stages
    wire is_bound     = insn_valid && (insn_class == LVX_IC_BOUND) && !invop;
    wire bound_wait   = is_bound && !bound_pend_q;

    // ------------------------------------------------------------
    // debug causes
    // ------------------------------------------------------------
    logic [LVX_DC_W-1:0] dbg_en;
    always_comb
    begin
        dbg_en              = debug_control_register;
        dbg_en[LVX_DC_STEP] = single_step_flag;
        dbg_en[LVX_DC_GDET] = general_detect_bit && is_cls_dreg;
    end

    // resume flag hides the instruction breakpoint for one instruction
    logic [LVX_DC_W-1:0] dbg_hit;
    always_comb
    begin
        dbg_hit              = dbg_match & dbg_en;
        dbg_hit[LVX_DC_INSN] = dbg_hit[LVX_DC_INSN] && !resume_flag_q;
    end

    wire dbg_op_trap  = insn_opcode == LVX_OP_DBG_TRAP && !ud_basic;
    wire dbg_fault_c  = dbg_hit[LVX_DC_INSN] || dbg_hit[LVX_DC_GDET];
    wire dbg_any      = insn_valid && !bound_pend_q && !invop
                        && (dbg_fault_c || (insn_done && (|dbg_hit || dbg_op_trap)));
    wire dbg_fault    = dbg_fault_c;

    // ------------------------------------------------------------
    // other traps
    // ------------------------------------------------------------
    wire is_break1    = insn_class == LVX_IC_BREAK1;
    wire bp_trap      = insn_valid && insn_done && is_break1 && !invop;
    wire ovf_trap     = insn_valid && insn_done && !invop
                        && insn_class == LVX_IC_OVFCHK && overflow_flag;

    // ------------------------------------------------------------
    // nmi at instruction boundary
    // ------------------------------------------------------------
    logic nmi_pend_q;
    wire boundary     = insn_valid && insn_done && !bound_wait;
    wire irtn_done    = boundary && insn_class == LVX_IC_IRTN;
    wire nmi_take     = (nmi_pend_q || nmi_req) && !nmi_blocked_q && boundary
                        && !invop && !dbg_any && !bound_fault
                        && !bp_trap && !ovf_trap;

    // ------------------------------------------------------------
    // selection of the delivered exception
    // ------------------------------------------------------------
    wire        any_exc  = invop || bound_fault || dbg_any || bp_trap || ovf_trap || nmi_take;
    wire [7:0]  vec_sel  = invop       ? LVX_VEC_INVOP :
                           bound_fault ? LVX_VEC_BOUND :
                           dbg_any     ? LVX_VEC_DEBUG :
                           bp_trap     ? LVX_VEC_BP :
                           ovf_trap    ? LVX_VEC_OVF :
                           nmi_take    ? LVX_VEC_NMI : LVX_VEC_NONE;
    wire        flt_sel  = invop || bound_fault || (dbg_any && dbg_fault);
    // debug pushes resume flag zero, others push one
    wire        rf_push  = !(vec_sel == LVX_VEC_DEBUG)
                           && (vec_sel != LVX_VEC_NONE || insn_string_intr);

    // ------------------------------------------------------------
    // resume flag
    // ------------------------------------------------------------
    logic rf_delay_q;
    wire  delays_clear = insn_class == LVX_IC_IRTN || insn_class == LVX_IC_JMP
                         || insn_class == LVX_IC_CALL || insn_class == LVX_IC_SWINT_TG;
    wire  clean_retire = boundary && !any_exc;
    logic rf_d;
    always_comb
    begin
        rf_d = resume_flag_q;
        if (clean_retire && !rf_delay_q && !delays_clear)
            rf_d = 1'b0;
        else if (clean_retire && rf_delay_q)
            rf_d = 1'b0;
        if (resume_flag_load)
            rf_d = resume_flag_value;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            resume_flag_q <= 1'b0;
            rf_delay_q    <= 1'b0;
        end
        else
        begin
            resume_flag_q <= rf_d;
            rf_delay_q    <= clean_retire ? delays_clear : rf_delay_q;
        end
    end

    // ------------------------------------------------------------
    // exception output registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            exc_valid_q     <= 1'b0;
            exc_vector_q    <= LVX_VEC_NONE;
            exc_fault_q     <= 1'b0;
            exc_pushed_rf_q <= 1'b0;
        end
        else
        begin
            exc_valid_q     <= any_exc;
            exc_vector_q    <= vec_sel;
            exc_fault_q     <= flt_sel;
            exc_pushed_rf_q <= any_exc ? rf_push : insn_string_intr;
        end
    end

    // ------------------------------------------------------------
    // debug status, nmi state, bound stage
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
            debug_status_register_q <= LVX_DC_RESET;
        else if (dbg_any && !bound_fault)
            debug_status_register_q <= dbg_hit;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            nmi_pend_q    <= 1'b0;
            nmi_blocked_q <= 1'b0;
            bound_pend_q  <= 1'b0;
        end
        else
        begin
            nmi_pend_q    <= (nmi_pend_q || nmi_req) && !nmi_take;
            nmi_blocked_q <= nmi_take || (nmi_blocked_q && !irtn_done);
            bound_pend_q  <= bound_wait;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_invop_fault: assert property (invop |=> exc_valid_q
        && exc_vector_q == LVX_VEC_INVOP && exc_fault_q)
        else $error("invalid opcode not delivered as fault");
    a_bp_trap_vec: assert property (bp_trap && !dbg_any && !bound_fault
        |=> exc_valid_q && exc_vector_q == LVX_VEC_BP && !exc_fault_q)
        else $error("breakpoint not a trap on vector 3");
    a_ovf_trap_vec: assert property (ovf_trap && !dbg_any && !bound_fault
        |=> exc_valid_q && exc_vector_q == LVX_VEC_OVF && !exc_fault_q)
        else $error("overflow not delivered as trap");
    a_bound_two_cycle: assert property (is_bound && !bound_pend_q
        && !$past(bound_wait) |=> bound_pend_q) else $error("bound check did not stage");
    a_nmi_block_hold: assert property (nmi_blocked_q && !irtn_done |=> nmi_blocked_q)
        else $error("nmi block dropped without interrupt return");
    a_nmi_no_retake: assert property (nmi_blocked_q |-> !nmi_take)
        else $error("nmi taken while blocked");
    a_dbg_rf_zero: assert property (exc_valid_q && exc_vector_q == LVX_VEC_DEBUG
        |-> !exc_pushed_rf_q) else $error("debug pushed resume flag set");
    a_nondbg_rf_one: assert property (exc_valid_q && exc_vector_q != LVX_VEC_DEBUG
        |-> exc_pushed_rf_q) else $error("non-debug pushed resume flag clear");
    a_rf_suppress: assert property (resume_flag_q |-> !dbg_hit[LVX_DC_INSN])
        else $error("instruction breakpoint with resume flag set");
    a_rf_clears: assert property (clean_retire && !delays_clear && !rf_delay_q
        && !resume_flag_load |=> !resume_flag_q) else $error("resume flag not cleared");
    a_nmi_vec_gen: assert property (nmi_take |=> exc_vector_q == LVX_VEC_NMI
        ##1 nmi_blocked_q || $past(irtn_done)) else $error("nmi not delivered on vector 2");

    c_nmi_taken:  cover property (nmi_take ##[1:20] irtn_done);
    c_dbg_fault:  cover property (dbg_any && dbg_fault);
    c_bound_flt:  cover property (bound_fault);
    c_rf_skip:    cover property (resume_flag_q && dbg_match[LVX_DC_INSN] && clean_retire);
endmodule

// >>> lvx_pkg.sv
package lvx_pkg;
    // ------------------------------------------------------------
    // vectors
    // ------------------------------------------------------------
    localparam logic [7:0] LVX_VEC_DEBUG = 8'h01;
    localparam logic [7:0] LVX_VEC_NMI   = 8'h02;
    localparam logic [7:0] LVX_VEC_BP    = 8'h03;
    localparam logic [7:0] LVX_VEC_OVF   = 8'h04;
    localparam logic [7:0] LVX_VEC_BOUND = 8'h05;
    localparam logic [7:0] LVX_VEC_INVOP = 8'h06;
    localparam logic [7:0] LVX_VEC_NONE  = 8'h00;
    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] LVX_OP_DBG_TRAP = 8'hf1;
    localparam logic [7:0] LVX_OP_FAR_CALL = 8'h9a;
    localparam logic [7:0] LVX_OP_FAR_JMP  = 8'hea;
    // ------------------------------------------------------------
    // debug cause bits (debug status)
    // ------------------------------------------------------------
    localparam int LVX_DC_W     = 8;
    localparam int LVX_DC_INSN  = 0;
    localparam int LVX_DC_STEP  = 1;
    localparam int LVX_DC_DRD   = 2;
    localparam int LVX_DC_DWR   = 3;
    localparam int LVX_DC_IORD  = 4;
    localparam int LVX_DC_IOWR  = 5;
    localparam int LVX_DC_TASK  = 6;
    localparam int LVX_DC_GDET  = 7;
    localparam logic [LVX_DC_W-1:0] LVX_DC_RESET = 8'h00;
    // ------------------------------------------------------------
    // instruction classes from decode
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        LVX_IC_OTHER,
        LVX_IC_BREAK1,
        LVX_IC_OVFCHK,
        LVX_IC_BOUND,
        LVX_IC_UNDEF,
        LVX_IC_IRTN,
        LVX_IC_JMP,
        LVX_IC_CALL,
        LVX_IC_SWINT_TG,
        LVX_IC_DESC,
        LVX_IC_SYSFAST,
        LVX_IC_SMX,
        LVX_IC_DREG
    } lvx_iclass_t;
endpackage

// >>> lvx_bound_cmp.sv
`timescale 1ns/10ps
// bounds comparator, registered result
module lvx_bound_cmp
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [63:0] index,
    input  wire logic [63:0] lower,
    input  wire logic [63:0] upper,
    output logic             outside_q
);
    always_ff @(posedge clk)
    begin
        if (srst)
            outside_q <= 1'b0;
        else
            outside_q <= ($signed(index) < $signed(lower)) || ($signed(index) > $signed(upper));
    end
endmodule

// >>> lvx_handler_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// system side and handler: raises nmi, stacks and restores flags
// ------------------------------------------------------------
module lvx_handler_model
    import lvx_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        fire_nmi,
    input  wire logic        do_return,
    input  wire logic        sets_rf,
    input  wire logic [15:0] cur_ptr,
    input  wire logic        exc_valid_q,
    input  wire logic [7:0]  exc_vector_q,
    input  wire logic        exc_fault_q,
    input  wire logic        exc_pushed_rf_q,
    output logic             nmi_q,
    output logic             rload_q,
    output logic             rvalue_q,
    output logic [15:0]      ret_ptr_q
);
    logic [7:0]  vec_q;
    logic        img_rf_q;
    logic [15:0] saved_q;
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            nmi_q    <= 1'b0;
            rload_q  <= 1'b0;
            img_rf_q <= 1'b0;
        end
        else
        begin
            nmi_q   <= fire_nmi;
            rload_q <= do_return;
            if (exc_valid_q)
            begin
                vec_q    <= exc_vector_q;
                img_rf_q <= exc_pushed_rf_q | (sets_rf & (exc_vector_q == LVX_VEC_DEBUG));
                saved_q  <= exc_fault_q ? cur_ptr : cur_ptr + 16'h0001;
            end
            if (do_return)
            begin
                rvalue_q  <= img_rf_q;
                // one-byte breakpoint: restart on the overwritten instruction
                ret_ptr_q <= (vec_q == LVX_VEC_BP) ? saved_q - 16'h0001 : saved_q;
            end
        end
    end
endmodule

// >>> low_vector_exception_logic_tb.sv
`timescale 1ns/10ps
module low_vector_exception_logic_tb;
    import lvx_pkg::*;
    typedef struct {
        lvx_iclass_t c;
        logic [7:0]  op;
        logic [21:0] fx;
        logic [7:0]  dm;
        logic [7:0]  de;
        logic [2:0]  ev;
        logic        ef;
    } lvx_row_t;
    // fx flips bits of the base: 0 rsv,1 lock,2 lockable,3 mem,4 badop,5 leg64,6 legvec,7 media,
    // 8 vfp,9 ovf,10 m64,11 long,12 prot,13 v86,14 sm,15 save,16 exc,17 em,18 dext,19 step,20 gdet,21 str
    localparam logic [21:0] BASE = 22'h019000;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        insn_valid = 1'b0;
    logic        insn_done = 1'b0;
    lvx_iclass_t insn_class = LVX_IC_OTHER;
    logic [7:0]  insn_opcode = 8'h00;
    logic [7:0]  dm = 8'h00;
    logic [7:0]  de = 8'h00;
    logic [21:0] fl = BASE;
    logic [63:0] bidx = 64'h0;
    logic [63:0] blo = 64'h0;
    logic [63:0] bhi = 64'h0;
    logic        fire_nmi = 1'b0;
    logic        do_return = 1'b0;
    logic        sets_rf = 1'b0;
    logic [15:0] ip = 16'h0000;
    logic [15:0] p, ret_ptr_q;
    logic        exc_valid_q, exc_fault_q, exc_pushed_rf_q, resume_flag_q, nmi_blocked_q;
    logic [7:0]  exc_vector_q, debug_status_register_q, v, v2, st;
    logic        nmi_q, rload_q, rvalue_q, s, s2, f, rf;
    logic [20:0] outs;
    int          fails = 0;
    int          checks = 0;
    lvx_row_t    rows[$];
    lvx_iclass_t dl[4] = '{LVX_IC_IRTN, LVX_IC_JMP, LVX_IC_CALL, LVX_IC_SWINT_TG};
    lvx_row_t    hit = '{LVX_IC_OTHER, 8'h00, 22'h0, 8'h01, 8'h01, 3'h1, 1'b1};
    lvx_row_t    plain = '{LVX_IC_OTHER, 8'h00, 22'h0, 8'h00, 8'h00, 3'h0, 1'b0};
    assign outs = {exc_valid_q, exc_vector_q, exc_fault_q, exc_pushed_rf_q,
                   resume_flag_q, debug_status_register_q, nmi_blocked_q};
    always #2.5 clk = ~clk;
    lvx_low_vector dut_u (
        .clk(clk), .srst(srst), .insn_valid(insn_valid), .insn_done(insn_done),
        .insn_class(insn_class), .insn_opcode(insn_opcode), .insn_reserved(fl[0]),
        .insn_lock(fl[1]), .insn_lockable(fl[2]), .insn_mem_target(fl[3]),
        .insn_bad_operand(fl[4]), .insn_legacy64(fl[5]), .insn_string_intr(fl[21]),
        .insn_legacy_vec(fl[6]), .insn_media(fl[7]), .insn_vec_fp_numexc(fl[8]),
        .insn_dreg_num(insn_opcode[2:0]), .bound_index_gt(1'b0), .bound_index(bidx),
        .bound_lower(blo), .bound_upper(bhi), .dbg_match(dm), .debug_control_register(de),
        .general_detect_bit(fl[20]), .single_step_flag(fl[19]), .overflow_flag(fl[9]),
        .resume_flag_load(rload_q), .resume_flag_value(rvalue_q), .mode_64bit(fl[10]),
        .mode_long(fl[11]), .mode_protected(fl[12]), .mode_v86(fl[13]),
        .system_management_mode(fl[14]), .os_vector_save_support_bit(fl[15]),
        .os_vector_exception_support_bit(fl[16]), .emulation_bit(fl[17]),
        .debug_extensions_bit(fl[18]), .nmi_req(nmi_q), .exc_valid_q(exc_valid_q),
        .exc_vector_q(exc_vector_q), .exc_fault_q(exc_fault_q),
        .exc_pushed_rf_q(exc_pushed_rf_q), .resume_flag_q(resume_flag_q),
        .debug_status_register_q(debug_status_register_q), .nmi_blocked_q(nmi_blocked_q));
    lvx_handler_model model_u (
        .clk(clk), .srst(srst), .fire_nmi(fire_nmi), .do_return(do_return),
        .sets_rf(sets_rf), .cur_ptr(ip), .exc_valid_q(exc_valid_q),
        .exc_vector_q(exc_vector_q), .exc_fault_q(exc_fault_q),
        .exc_pushed_rf_q(exc_pushed_rf_q), .nmi_q(nmi_q), .rload_q(rload_q),
        .rvalue_q(rvalue_q), .ret_ptr_q(ret_ptr_q));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: value %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // present one instruction, then watch a bounded window for the exception pulse
    task automatic run(input lvx_row_t r, input int hold);
        @(posedge clk);
        #1;
        insn_class = r.c;
        insn_opcode = r.op;
        fl = BASE ^ r.fx;
        dm = r.dm;
        de = r.de;
        ip = ip + 16'h0001;
        insn_valid = 1'b1;
        insn_done = 1'b1;
        repeat (hold) @(posedge clk);
        #1;
        insn_valid = 1'b0;
        insn_done = 1'b0;
        dm = 8'h00;
        s = 1'b0;
        for (int i = 0; i < 3 && !s; i++)
        begin
            if (exc_valid_q === 1'b1)
            begin
                s = 1'b1;
                v = exc_vector_q;
                f = exc_fault_q;
                rf = exc_pushed_rf_q;
            end
            else
            begin
                @(posedge clk);
                #1;
            end
        end
    endtask
    task automatic ins(input lvx_iclass_t c, input logic [7:0] op, input logic [21:0] fx,
                       input logic [2:0] ev, input logic ef);
        rows.push_back(lvx_row_t'{c, op, fx, 8'h00, 8'h00, ev, ef});
    endtask
    task automatic dbg(input logic [21:0] fx, input logic [7:0] m, input logic [7:0] e,
                       input logic [2:0] ev, input logic ef);
        rows.push_back(lvx_row_t'{m[7] ? LVX_IC_DREG : LVX_IC_OTHER, 8'h00, fx, m, e, ev, ef});
    endtask
    task automatic bnd(input logic [63:0] i_v, input logic [63:0] lo, input logic [63:0] hi,
                       input logic out);
        bidx = i_v;
        blo = lo;
        bhi = hi;
        run(lvx_row_t'{LVX_IC_BOUND, 8'h00, 22'h0, 8'h00, 8'h00, 3'h5, 1'b1}, 2);
        chk(s, out);
        if (out)
            chk({v, f, rf}, {8'h05, 1'b1, 1'b1});
    endtask
    task automatic pulse(input logic ret);
        @(posedge clk);
        #1;
        if (ret) do_return = 1'b1; else fire_nmi = 1'b1;
        @(posedge clk);
        #1;
        do_return = 1'b0;
        fire_nmi = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        ins(LVX_IC_BREAK1, 8'h00, 22'h0, 3'h3, 1'b0);
        ins(LVX_IC_OVFCHK, 8'h00, 22'h200, 3'h4, 1'b0);
        ins(LVX_IC_OVFCHK, 8'h00, 22'h0, 3'h0, 1'b0);
        ins(LVX_IC_UNDEF, 8'h00, 22'h0, 3'h6, 1'b1);
        ins(LVX_IC_OTHER, 8'h00, 22'h1, 3'h6, 1'b1);
        ins(LVX_IC_OTHER, 8'h00, 22'h2, 3'h6, 1'b1);
        ins(LVX_IC_OTHER, 8'h00, 22'h6, 3'h6, 1'b1);
        ins(LVX_IC_OTHER, 8'h00, 22'he, 3'h0, 1'b0);
        ins(LVX_IC_OTHER, 8'h00, 22'h10, 3'h6, 1'b1);
        ins(LVX_IC_OTHER, 8'h00, 22'h420, 3'h6, 1'b1);
        ins(LVX_IC_CALL, 8'h9a, 22'h400, 3'h6, 1'b1);
        ins(LVX_IC_JMP, 8'hea, 22'h400, 3'h6, 1'b1);
        ins(LVX_IC_SYSFAST, 8'h00, 22'h800, 3'h6, 1'b1);
        ins(LVX_IC_SMX, 8'h00, 22'h0, 3'h6, 1'b1);
        ins(LVX_IC_SMX, 8'h00, 22'h4000, 3'h0, 1'b0);
        ins(LVX_IC_DESC, 8'h00, 22'h1000, 3'h6, 1'b1);
        ins(LVX_IC_DESC, 8'h00, 22'h2000, 3'h6, 1'b1);
        ins(LVX_IC_OTHER, 8'h00, 22'h8040, 3'h6, 1'b1);
        ins(LVX_IC_OTHER, 8'h00, 22'h20080, 3'h6, 1'b1);
        ins(LVX_IC_OTHER, 8'h00, 22'h10100, 3'h6, 1'b1);
        ins(LVX_IC_DREG, 8'h04, 22'h40000, 3'h6, 1'b1);
        ins(LVX_IC_DREG, 8'h05, 22'h40000, 3'h6, 1'b1);
        ins(LVX_IC_DREG, 8'h04, 22'h0, 3'h0, 1'b0);
        ins(LVX_IC_OTHER, 8'hf1, 22'h0, 3'h1, 1'b0);
        dbg(22'h0, 8'h04, 8'h04, 3'h1, 1'b0);
        dbg(22'h0, 8'h04, 8'h00, 3'h0, 1'b0);
        dbg(22'h80000, 8'h02, 8'h00, 3'h1, 1'b0);
        dbg(22'h0, 8'h02, 8'hff, 3'h0, 1'b0);
        dbg(22'h0, 8'h01, 8'h01, 3'h1, 1'b1);
        dbg(22'h100000, 8'h80, 8'h00, 3'h1, 1'b1);
        dbg(22'h0, 8'h78, 8'h28, 3'h1, 1'b0);
        dbg(22'h0, 8'h50, 8'h50, 3'h1, 1'b0);
        repeat (6) @(posedge clk);
        #1;
        srst = 1'b0;
        chk(outs, 21'h0);
        foreach (rows[i])
        begin
            run(rows[i], 1);
            chk(s, rows[i].ev != 3'h0);
            if (s === 1'b1 && rows[i].ev != 3'h0)
            begin
                chk(v, rows[i].ev);
                chk(f, rows[i].ef);
                chk(rf, rows[i].ev != 3'h1);
                st = rows[i].dm & {rows[i].fx[20], rows[i].de[6:2], rows[i].fx[19], rows[i].de[0]};
                if (rows[i].dm != 8'h00)
                    chk(debug_status_register_q, st);
            end
        end
        bnd(64'h3, 64'h0, 64'h5, 1'b0);
        bnd(64'h5, 64'h0, 64'h5, 1'b0);
        bnd(64'h6, 64'h0, 64'h5, 1'b1);
        bnd(64'hffff_ffff_ffff_fffd, 64'hffff_ffff_ffff_fffe, 64'h5, 1'b1);
        sets_rf = 1'b1;
        run(hit, 1);
        chk({s, rf}, 2'b10);
        pulse(1'b1);
        chk(resume_flag_q, 1'b1);
        run(hit, 1);
        chk({s, resume_flag_q}, 2'b00);
        run(hit, 1);
        chk(s, 1'b1);
        sets_rf = 1'b0;
        foreach (dl[k])
        begin
            run(lvx_row_t'{LVX_IC_BREAK1, 8'h00, 22'h0, 8'h00, 8'h00, 3'h3, 1'b0}, 1);
            p = ip;
            pulse(1'b1);
            chk(ret_ptr_q, p);
            run(lvx_row_t'{dl[k], 8'h00, 22'h0, 8'h00, 8'h00, 3'h0, 1'b0}, 1);
            chk(resume_flag_q, 1'b1);
            run(plain, 1);
            chk(resume_flag_q, 1'b0);
        end
        pulse(1'b0);
        run(lvx_row_t'{LVX_IC_OTHER, 8'h00, 22'h200000, 8'h00, 8'h00, 3'h2, 1'b0}, 1);
        chk({s, v, f, rf, nmi_blocked_q}, {1'b1, 8'h02, 1'b0, 1'b1, 1'b1});
        pulse(1'b0);
        run(plain, 1);
        chk(s, 1'b0);
        run(lvx_row_t'{LVX_IC_IRTN, 8'h00, 22'h0, 8'h00, 8'h00, 3'h0, 1'b0}, 1);
        s2 = s;
        v2 = v;
        run(plain, 1);
        chk({s2 | s, s2 ? v2 : v}, {1'b1, 8'h02});
        srst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        srst = 1'b0;
        chk(outs, 21'h0);
        complete_run();
    end
endmodule
